// ---- logic/sgcr_regs.v ----
// Purpose: Global control registers of a four-port managed switch
// Assumes: Management logic (SPI/SMI) on the same clock gives
//          single-cycle read and write strobes with an index
// Notes:   Read data is registered, one cycle after the strobe
`default_nettype none
`include "sgcr_map.vh"

module sgcr_regs #(
    parameter integer FAST_CYC =
        `SGCR_PERIOD_FAST_MS * `SGCR_CLK_KHZ,
    parameter integer SLOW_CYC =
        `SGCR_PERIOD_SLOW_MS * `SGCR_CLK_KHZ,
    parameter integer CNT_W    = 27
) (
    input  wire        clk,
    input  wire        reset_n,
    // Register port from management logic
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rvalid,
    // Strap pins, sampled at the end of reset
    input  wire        duplex_strap_pin,
    input  wire        flow_ctrl_strap_pin,
    input  wire        speed_strap_pin,
    input  wire        led_mode_strap_pin,
    // Host port controls
    output wire        host_port_mii_backpres,
    output wire        host_port_mii_half_dup,
    output wire        host_port_mii_flow_ctrl,
    output wire        host_port_mii_speed_10,
    // Null VLAN ID replacement path
    input  wire        vid_valid,
    input  wire [11:0] rx_vid,
    input  wire [11:0] port_vid,
    output reg  [11:0] vid_out,
    output reg         vid_out_valid,
    // Broadcast storm control
    output wire [10:0] storm_threshold,
    output reg         storm_tick_fast,
    output reg         storm_tick_slow,
    // Clock edges and power
    output wire        third_port_rmii_neg_edge,
    output wire        host_port_rmii_neg_edge,
    output wire        phy_power_save,
    output wire        mgmt_read_neg_edge,
    // LED sources and drives
    input  wire        link_act,
    input  wire        speed_100,
    input  wire        full_duplex,
    output reg         port_led_one,
    output reg         port_led_zero
);

    // Reset release synchroniser
    reg        rst_meta;
    reg        rst_n_s;

    // Strap synchronisers, three stages each
    reg  [3:0] strap_s1;
    reg  [3:0] strap_s2;
    reg  [3:0] strap_s3;
    reg        strap_done;
    wire [3:0] strap_pins;
    wire       strap_agree;
    reg  [1:0] strap_fill;

    // Registers
    reg  [7:0] port4_link_config;
    reg  [7:0] storm_rate_low;
    reg  [7:0] clock_edge_led_config;

    // Decode
    wire       wr_port4;
    wire       wr_storm;
    wire       wr_edge;
    reg  [7:0] next_rdata;

    // Period counters
    reg  [CNT_W-1:0] fast_cnt;
    reg  [CNT_W-1:0] slow_cnt;

    // Order: duplex, flow, speed, led mode
    assign strap_pins = {duplex_strap_pin, flow_ctrl_strap_pin,
                         speed_strap_pin, led_mode_strap_pin};

    // Release reset through two flops; assertion stays immediate
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n_s  <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n_s  <= rst_meta;
        end
    end

    // Pins are asynchronous, so three stages before the load, two before the compare
    always @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            strap_s1 <= 4'h0;
            strap_s2 <= 4'h0;
            strap_s3 <= 4'h0;
        end else begin
            strap_s1 <= strap_pins;
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
        end
    end

    // Stages leave reset at zero, so an early agreement would only
    // compare reset values; wait until the pins have filled the pipe
    always @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            strap_fill <= 2'b00;
        end else if (strap_fill != `SGCR_STRAP_FILL) begin
            strap_fill <= strap_fill + 2'b01;
        end
    end

    // A level counts once the pipe is full and the last two stages
    // agree; a strap still bouncing then just delays the load
    assign strap_agree = (strap_fill == `SGCR_STRAP_FILL) &&
                         (strap_s2 == strap_s3);

    // Register bank writes; read-only test registers take none
    assign wr_port4 = reg_wr && (reg_addr == `SGCR_OFS_PORT4_CFG);
    assign wr_storm = reg_wr && (reg_addr == `SGCR_OFS_STORM_LOW);
    assign wr_edge  = reg_wr && (reg_addr == `SGCR_OFS_EDGE_LED);

    // Strap load happens once; a write in that same cycle wins
    always @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            strap_done            <= 1'b0;
            port4_link_config     <= `SGCR_RST_PORT4_CFG;
            storm_rate_low        <= `SGCR_RST_STORM_LOW;
            clock_edge_led_config <= `SGCR_RST_EDGE_LED;
        end else begin
            if (!strap_done && strap_agree) begin
                strap_done <= 1'b1;
                port4_link_config[`SGCR_BIT_HALF_DUP] <=
                    strap_s3[3];
                port4_link_config[`SGCR_BIT_FLOW_CTRL] <=
                    strap_s3[2];
                port4_link_config[`SGCR_BIT_SPEED_10] <=
                    strap_s3[1];
                clock_edge_led_config[`SGCR_BIT_LED_MODE] <=
                    strap_s3[0];
            end
            if (wr_port4) begin
                port4_link_config <= reg_wdata;
            end
            if (wr_storm) begin
                storm_rate_low <= reg_wdata;
            end
            if (wr_edge) begin
                // Reserved bits 5, 4 and 2 stay zero
                clock_edge_led_config <=
                    reg_wdata & `SGCR_EDGE_RW_MASK;
            end
        end
    end

    // Read mux; unmapped offsets read as zero
    always @* begin
        next_rdata = 8'h00;
        case (reg_addr)
            `SGCR_OFS_PORT4_CFG: next_rdata = port4_link_config;
            `SGCR_OFS_STORM_LOW: next_rdata = storm_rate_low;
            `SGCR_OFS_TEST_A:    next_rdata = `SGCR_RST_TEST_A;
            `SGCR_OFS_TEST_B:    next_rdata = `SGCR_RST_TEST_B;
            `SGCR_OFS_TEST_C:    next_rdata = `SGCR_RST_TEST_C;
            `SGCR_OFS_EDGE_LED:  next_rdata = clock_edge_led_config;
            default:             next_rdata = 8'h00;
        endcase
    end

    // Registered read answer, one cycle after the strobe
    always @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // Host port control levels
    assign host_port_mii_backpres =
        port4_link_config[`SGCR_BIT_BACKPRES];
    assign host_port_mii_half_dup =
        port4_link_config[`SGCR_BIT_HALF_DUP];
    assign host_port_mii_flow_ctrl =
        port4_link_config[`SGCR_BIT_FLOW_CTRL];
    assign host_port_mii_speed_10 =
        port4_link_config[`SGCR_BIT_SPEED_10];

    // Threshold in 64-byte blocks: three high bits, then low byte
    assign storm_threshold =
        {port4_link_config[`SGCR_STORM_HI_MSB:0],
         storm_rate_low};

    // Edge, power and read-launch selects
    assign third_port_rmii_neg_edge =
        clock_edge_led_config[`SGCR_BIT_EDGE_P3];
    assign host_port_rmii_neg_edge =
        clock_edge_led_config[`SGCR_BIT_EDGE_P4];
    assign phy_power_save =
        clock_edge_led_config[`SGCR_BIT_PWR_SAVE];
    assign mgmt_read_neg_edge =
        clock_edge_led_config[`SGCR_BIT_RD_EDGE];

    // Null VID swap, one register stage so the output is clean
    always @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            vid_out       <= 12'h000;
            vid_out_valid <= 1'b0;
        end else begin
            vid_out_valid <= vid_valid;
            if (port4_link_config[`SGCR_BIT_NULL_VID] &&
                (rx_vid == 12'h000)) begin
                vid_out <= port_vid;
            end else begin
                vid_out <= rx_vid;
            end
        end
    end

    // Free-running storm periods; each port picks the tick that
    // matches its speed, so both run at all times
    always @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            fast_cnt        <= {CNT_W{1'b0}};
            slow_cnt        <= {CNT_W{1'b0}};
            storm_tick_fast <= 1'b0;
            storm_tick_slow <= 1'b0;
        end else begin
            storm_tick_fast <= 1'b0;
            storm_tick_slow <= 1'b0;
            if (fast_cnt == FAST_CYC[CNT_W-1:0] - 1'b1) begin
                fast_cnt        <= {CNT_W{1'b0}};
                storm_tick_fast <= 1'b1;
            end else begin
                fast_cnt <= fast_cnt + 1'b1;
            end
            if (slow_cnt == SLOW_CYC[CNT_W-1:0] - 1'b1) begin
                slow_cnt        <= {CNT_W{1'b0}};
                storm_tick_slow <= 1'b1;
            end else begin
                slow_cnt <= slow_cnt + 1'b1;
            end
        end
    end

    // LED function select; mode 1 shows 100M link and duplex
    always @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            port_led_one  <= 1'b0;
            port_led_zero <= 1'b0;
        end else if (clock_edge_led_config[`SGCR_BIT_LED_MODE]) begin
            port_led_one  <= link_act & speed_100;
            port_led_zero <= full_duplex;
        end else begin
            port_led_one  <= link_act;
            port_led_zero <= speed_100;
        end
    end

endmodule // sgcr_regs
`default_nettype wire

// ---- logic/sgcr_map.vh ----
// Purpose: Constants for the switch global control register bank
// Assumes: 8-bit register data, 8-bit register index, 250 MHz clock
// Notes:   Guarded against double inclusion
`ifndef SGCR_MAP_VH
`define SGCR_MAP_VH

// Register offsets
`define SGCR_OFS_PORT4_CFG 8'h06
`define SGCR_OFS_STORM_LOW 8'h07
`define SGCR_OFS_TEST_A    8'h08
`define SGCR_OFS_TEST_B    8'h09
`define SGCR_OFS_TEST_C    8'h0A
`define SGCR_OFS_EDGE_LED  8'h0B

// Field positions in port4_link_config
`define SGCR_BIT_BACKPRES  7
`define SGCR_BIT_HALF_DUP  6
`define SGCR_BIT_FLOW_CTRL 5
`define SGCR_BIT_SPEED_10  4
`define SGCR_BIT_NULL_VID  3
`define SGCR_STORM_HI_MSB  2

// Field positions in clock_edge_led_config
`define SGCR_BIT_EDGE_P3   7
`define SGCR_BIT_EDGE_P4   6
`define SGCR_BIT_PWR_SAVE  3
`define SGCR_BIT_LED_MODE  1
`define SGCR_BIT_RD_EDGE   0
`define SGCR_EDGE_RW_MASK  8'hCB

// Reset values
`define SGCR_RST_PORT4_CFG 8'h00
`define SGCR_RST_STORM_LOW 8'h4A
`define SGCR_RST_TEST_A    8'h00
`define SGCR_RST_TEST_B    8'h4C
`define SGCR_RST_TEST_C    8'h00
`define SGCR_RST_EDGE_LED  8'h00

// Timing
`define SGCR_CLK_KHZ       250000
`define SGCR_PERIOD_FAST_MS 50
`define SGCR_PERIOD_SLOW_MS 500
`define SGCR_STRAP_FILL    2'b11

`endif

// ---- verif/sgcr_host.sv ----
// Purpose: Host model driving the register port of the control bank
// Assumes: Strobes are one-cycle pulses taken on a rising edge
// Notes:   Read answer is awaited under a bounded count
`default_nettype none
module sgcr_host (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
    end
    // Test bytes are only written when a refusal is being probed
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Answer data is taken in the cycle that the valid pulse stands
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        q = 8'hXX;
        for (int i = 0; i < 3; i++) begin
            #1;
            if (reg_rvalid === 1'b1) begin
                q = reg_rdata;
                break;
            end
            @(posedge clk);
        end
    endtask
endmodule // sgcr_host
`default_nettype wire

// ---- verif/sgcr_regs_assertions.sv ----
// Purpose: Port-level checker for the global control bank
// Assumes: One clock; writes land on outputs the next cycle
// Notes:   Bound into every instance of the bank
`default_nettype none
module sgcr_regs_chk (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        host_port_mii_backpres,
    input wire logic        host_port_mii_half_dup,
    input wire logic        host_port_mii_flow_ctrl,
    input wire logic        host_port_mii_speed_10,
    input wire logic        vid_valid,
    input wire logic [11:0] rx_vid,
    input wire logic [11:0] vid_out,
    input wire logic [10:0] storm_threshold,
    input wire logic        third_port_rmii_neg_edge,
    input wire logic        host_port_rmii_neg_edge,
    input wire logic        mgmt_read_neg_edge
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Write strobes decoded once to keep the properties short
    wire logic w6 = reg_wr && (reg_addr == 8'h06);
    wire logic wb = reg_wr && (reg_addr == 8'h0B);
    property p_bp; w6 |=> host_port_mii_backpres == $past(reg_wdata[7]);
    endproperty
    a_bp: assert property (p_bp) else $error("back pressure bit");
    property p_hd; w6 |=> host_port_mii_half_dup == $past(reg_wdata[6]);
    endproperty
    a_hd: assert property (p_hd) else $error("duplex bit");
    property p_fc; w6 |=> host_port_mii_flow_ctrl == $past(reg_wdata[5]);
    endproperty
    a_fc: assert property (p_fc) else $error("flow control bit");
    property p_sp; w6 |=> host_port_mii_speed_10 == $past(reg_wdata[4]);
    endproperty
    a_sp: assert property (p_sp) else $error("speed bit");
    property p_vid; vid_valid && rx_vid != 12'h000 |=> vid_out == $past(rx_vid);
    endproperty
    a_vid: assert property (p_vid) else $error("vid passthrough");
    property p_thr; reg_wr && reg_addr == 8'h07
        |=> storm_threshold[7:0] == $past(reg_wdata); endproperty
    a_thr: assert property (p_thr) else $error("threshold low");
    property p_ro; reg_rd && reg_addr == 8'h09
        |=> reg_rvalid && reg_rdata == 8'h4C; endproperty
    a_ro: assert property (p_ro) else $error("test byte b");
    property p_edge; wb |=> third_port_rmii_neg_edge == $past(reg_wdata[7])
        && host_port_rmii_neg_edge == $past(reg_wdata[6]); endproperty
    a_edge: assert property (p_edge) else $error("rmii edges");
    property p_rde; wb |=> mgmt_read_neg_edge == $past(reg_wdata[0]);
    endproperty
    a_rde: assert property (p_rde) else $error("read edge");
endmodule // sgcr_regs_chk
bind sgcr_regs sgcr_regs_chk u_chk (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .host_port_mii_backpres(host_port_mii_backpres),
    .host_port_mii_half_dup(host_port_mii_half_dup),
    .host_port_mii_flow_ctrl(host_port_mii_flow_ctrl),
    .host_port_mii_speed_10(host_port_mii_speed_10),
    .vid_valid(vid_valid), .rx_vid(rx_vid), .vid_out(vid_out),
    .storm_threshold(storm_threshold),
    .third_port_rmii_neg_edge(third_port_rmii_neg_edge),
    .host_port_rmii_neg_edge(host_port_rmii_neg_edge),
    .mgmt_read_neg_edge(mgmt_read_neg_edge));
`default_nettype wire

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench for the global control bank
// Assumes: Short storm periods of 20 and 200 cycles
// Notes:   Table of write/read rows, then hand-written cases
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, reset_n, st_d, st_f, st_s, st_l, vv, la, s100, fd;
    logic [11:0] rv, pv, vo;
    logic [10:0] thr;
    logic [7:0]  ad, wd, rdat, q;
    logic        wr, rd, rval, one, zero, tf, ts;
    int          fails, n_checks, nf, ns;
    wire logic [3:0] hp, ed;
    wire logic       vov;
    // Rows: offset, written byte, byte read back
    logic [23:0] rows [0:7] = '{24'h06FFFF, 24'h071010, 24'h085500,
        24'h09554C, 24'h0A5500, 24'h0BFFCB, 24'h0C5500, 24'h060707};
    sgcr_regs #(.FAST_CYC(20), .SLOW_CYC(200)) dut (.clk(clk),
        .reset_n(reset_n), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdat), .reg_rvalid(rval),
        .duplex_strap_pin(st_d), .flow_ctrl_strap_pin(st_f),
        .speed_strap_pin(st_s), .led_mode_strap_pin(st_l),
        .host_port_mii_backpres(hp[3]), .host_port_mii_half_dup(hp[2]),
        .host_port_mii_flow_ctrl(hp[1]), .host_port_mii_speed_10(hp[0]),
        .vid_valid(vv), .rx_vid(rv), .port_vid(pv), .vid_out(vo),
        .vid_out_valid(vov), .storm_threshold(thr),
        .storm_tick_fast(tf), .storm_tick_slow(ts),
        .third_port_rmii_neg_edge(ed[3]), .host_port_rmii_neg_edge(ed[2]),
        .phy_power_save(ed[1]), .mgmt_read_neg_edge(ed[0]),
        .link_act(la), .speed_100(s100),
        .full_duplex(fd), .port_led_one(one), .port_led_zero(zero));
    sgcr_host u_host (.clk(clk), .reg_rdata(rdat), .reg_rvalid(rval),
        .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd));
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, q);
        chk({4'h0, q}, {4'h0, e});
        if ($isunknown(q)) results(); // A lost answer ends the run
    endtask
    // Reset held 12 cycles; straps steady well before release
    task automatic do_reset(input logic s);
        @(posedge clk);
        reset_n <= 1'b0;
        {st_d, st_f, st_s, st_l} <= {4{s}};
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (10) @(posedge clk);
    endtask
    task automatic vchk(input logic [11:0] r, input logic [11:0] e);
        @(posedge clk);
        rv <= r;
        vv <= 1'b1;
        @(posedge clk);
        vv <= 1'b0;
        #1 chk(vo, e);
        chk({11'h000, vov}, 12'h001);
    endtask
    task automatic results;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Hang guard: a stuck run counts as a mismatch
    initial begin
        #200us;
        fails++;
        results();
    end
    initial begin
        {reset_n, vv, la, s100, fd, st_d, st_f, st_s, st_l} = 9'h000;
        rv = 12'h000;
        pv = 12'h005;
        do_reset(1'b0);
        rc(8'h06, 8'h00);
        rc(8'h07, 8'h4A);
        chk({1'b0, thr}, 12'h04A);
        rc(8'h0B, 8'h00);
        $display("test reset values done");
        foreach (rows[i]) begin
            u_host.wr(rows[i][23:16], rows[i][15:8]);
            rc(rows[i][23:16], rows[i][7:0]);
        end
        chk({1'b0, thr}, 12'h710);
        chk({8'h00, ed}, 12'h00F);
        chk({8'h00, hp}, 12'h000);
        $display("test register table done");
        vchk(12'h000, 12'h000);
        u_host.wr(8'h06, 8'h08);
        vchk(12'h000, 12'h005);
        vchk(12'h003, 12'h003);
        $display("test null id done");
        @(posedge clk);
        {la, s100, fd} <= 3'b101;
        u_host.wr(8'h0B, 8'h02);
        repeat (2) @(posedge clk);
        #1 chk({10'h000, one, zero}, 12'h001);
        u_host.wr(8'h0B, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk({10'h000, one, zero}, 12'h002);
        $display("test led modes done");
        {nf, ns} = 0;
        repeat (400) begin
            @(posedge clk);
            #1;
            nf += (tf === 1'b1);
            ns += (ts === 1'b1);
        end
        chk(nf[11:0], 12'h014);
        chk(ns[11:0], 12'h002);
        $display("test storm periods done");
        do_reset(1'b1);
        rc(8'h06, 8'h70);
        chk({8'h00, hp}, 12'h007);
        u_host.wr(8'h06, 8'h00);
        rc(8'h06, 8'h00);
        rc(8'h0B, 8'h02);
        $display("test strap load done");
        results();
    end
endmodule // tb_top
`default_nettype wire
